// ---- hw/tbl_baseline.sv ----
`timescale 1ns/1ps
`default_nettype none
module tbl_baseline import tbl_pkg::*; #(
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // shared settings
  tbl_cfg_if.snk cfg,
  // samples
  input wire logic sample_valid,
  input wire logic [CNT_W-1:0] raw_count,
  // tracked baseline
  output logic [CNT_W-1:0] baseline
);

  typedef struct packed {
    logic primed;
    logic [CNT_W-1:0] base;
    logic [7:0] bucket;
  } tbl_bl_st_t;

  tbl_bl_st_t s_reg;
  tbl_bl_st_t s_next;
  logic [CNT_W-1:0] diff;
  logic [7:0] step;
  logic [8:0] sum;
  logic quiet;

  always_comb begin
    s_next = s_reg;
    diff = raw_count - s_reg.base;
    // a large jump only reaches the bucket with auto reset; clip it to one byte
    step = (diff > CNT_W'(8'hff)) ? 8'hff : diff[7:0];
    sum = {1'b0, s_reg.bucket} + {1'b0, step};
    quiet = diff < CNT_W'(cfg.noise_threshold_value);
    if (sample_valid) begin
      if (!s_reg.primed) begin
        s_next.primed = 1'b1;
        s_next.base = raw_count;
        s_next.bucket = 8'h00;
      end else if (raw_count > s_reg.base) begin
        if (quiet || cfg.sensor_auto_reset) begin
          if (sum >= {1'b0, cfg.bucket_fill_level}) begin
            s_next.base = (s_reg.base == '1) ? s_reg.base : s_reg.base + 1'b1;
            s_next.bucket = 8'h00;
          end else begin
            s_next.bucket = sum[7:0];
          end
        end
      end else if (raw_count < s_reg.base) begin
        // falling counts are followed at once so a release never sticks
        s_next.base = raw_count;
        s_next.bucket = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign baseline = s_reg.base;

endmodule
`default_nettype wire

// ---- hw/tbl_cfg_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface tbl_cfg_if;
  logic [7:0] noise_threshold_value;
  logic [7:0] bucket_fill_level;
  logic sensor_auto_reset;
  modport src (
    output noise_threshold_value,
    output bucket_fill_level,
    output sensor_auto_reset
  );
  modport snk (
    input noise_threshold_value,
    input bucket_fill_level,
    input sensor_auto_reset
  );
endinterface
`default_nettype wire

// ---- hw/tbl_out_logic.sv ----
`timescale 1ns/1ps
`default_nettype none
module tbl_out_logic import tbl_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // configuration
  input wire logic [7:0] output_logic_select,
  input wire logic [1:0] sensor_input_mask,
  input wire logic port_bit,
  input wire logic pin_enable,
  // sensor states
  input wire logic [1:0] sensor_state,
  // pin
  output logic pin,
  output logic pin_oe_n
);

  typedef struct packed {
    logic pin;
    logic oe_n;
  } tbl_out_st_t;

  tbl_out_st_t s_reg;
  tbl_out_st_t s_next;
  logic [1:0] picked;
  logic combined;

  always_comb begin
    s_next = s_reg;
    picked = sensor_state & sensor_input_mask;
    // an empty mask makes AND false rather than vacuously true
    if (output_logic_select[LSEL_AND_BIT]) begin
      combined = (sensor_input_mask != 2'h0) && ((sensor_state | ~sensor_input_mask) == 2'h3);
    end else begin
      combined = |picked;
    end
    if (output_logic_select[LSEL_ON_BIT]) begin
      s_next.pin = combined ^ output_logic_select[LSEL_INV_BIT];
    end else begin
      s_next.pin = port_bit;
    end
    s_next.oe_n = ~pin_enable;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_reg.pin <= 1'b0;
      s_reg.oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pin = s_reg.pin;
  assign pin_oe_n = s_reg.oe_n;

endmodule
`default_nettype wire

// ---- hw/tbl_pkg.sv ----
package tbl_pkg;

  // register offsets
  localparam logic [7:0] OFF_OUT_STATUS = 8'h00;
  localparam logic [7:0] OFF_OUT_PORT = 8'h04;
  localparam logic [7:0] OFF_LSEL0 = 8'h1c;
  localparam logic [7:0] OFF_LIN0 = 8'h1e;
  localparam logic [7:0] OFF_LSEL1 = 8'h21;
  localparam logic [7:0] OFF_LIN1 = 8'h23;
  localparam logic [7:0] OFF_NOISE = 8'h4e;
  localparam logic [7:0] OFF_BL_UPD = 8'h4f;
  localparam logic [7:0] OFF_SETTLE = 8'h50;
  localparam logic [7:0] OFF_CLK_AR = 8'h51;
  localparam logic [7:0] OFF_COMMAND = 8'ha0;

  // field positions
  localparam int unsigned LSEL_ON_BIT = 7;
  localparam int unsigned LSEL_INV_BIT = 1;
  localparam int unsigned LSEL_AND_BIT = 0;
  localparam int unsigned CLK_SEL_LSB = 4;
  localparam int unsigned AUTO_RST_BIT = 3;
  localparam logic [7:0] LSEL_WMASK = 8'h83;
  localparam logic [7:0] CLK_AR_WMASK = 8'h38;

  // values after reset
  localparam logic [7:0] RST_LSEL = 8'h00;
  localparam logic [7:0] RST_LIN0 = 8'h01;
  localparam logic [7:0] RST_LIN1 = 8'h02;
  localparam logic [7:0] RST_NOISE = 8'h28;
  localparam logic [7:0] RST_BL_UPD = 8'h64;
  localparam logic [7:0] RST_SETTLE = 8'ha0;
  localparam logic [7:0] RST_CLK_AR = 8'h00;
  localparam logic [1:0] RST_OUT_PORT = 2'h0;

  // commands and counts
  localparam logic [7:0] CMD_NORMAL = 8'h07;
  localparam logic [7:0] CMD_SETUP = 8'h08;
  localparam logic [7:0] SETTLE_MIN = 8'h02;

  typedef enum logic [1:0] {
    TBL_MODE_NORMAL = 2'b01,
    TBL_MODE_SETUP = 2'b10
  } tbl_mode_t;

  typedef enum logic [1:0] {
    TBL_ST_IDLE = 2'b01,
    TBL_ST_SETTLE = 2'b10
  } tbl_settle_t;

  // low bits of the divider that must be all ones for a sense tick
  function automatic logic [2:0] tbl_div_mask(input logic [1:0] code);
    logic [2:0] m;
    m = 3'h0;
    case (code)
      2'h1: m = 3'h1;
      2'h2: m = 3'h3;
      2'h3: m = 3'h7;
      default: m = 3'h0;
    endcase
    return m;
  endfunction

endpackage

// ---- hw/tbl_top.sv ----
// Behaviour
// - one logic select register per output
// - select write ignored while pin disabled
// - bit 7 enables the logic function
// - bit 1 inverts the logic result
// - bit 0 chooses OR or AND
// - input mask bits 1:0 pick sensors
// - no baseline update above noise threshold
// - small positive difference fills the bucket
// - full bucket bumps baseline, empties bucket
// - settling value sets conversion delay length
// - sense clock divides by 1,2,4,8
// - auto reset updates baseline continuously
// - settling and clock registers setup-mode only
// - shared settings apply to every channel
// - port writes leave logic-driven pins alone
// - command 08 setup, 07 normal mode
`timescale 1ns/1ps
`default_nettype none
module tbl_top import tbl_pkg::*; #(
  parameter int unsigned NUM_CH = 2,
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register access
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  output logic setup_mode,
  // sensing core
  input wire logic [NUM_CH-1:0] sensor_active,
  input wire logic [NUM_CH-1:0] sample_valid,
  input wire logic [NUM_CH-1:0][CNT_W-1:0] raw_count,
  output logic [NUM_CH-1:0][CNT_W-1:0] baseline,
  input wire logic conv_start,
  output logic sense_tick,
  output logic settle_busy,
  output logic settle_done,
  // output pins
  input wire logic [NUM_CH-1:0] pin_enable,
  output logic [NUM_CH-1:0] output_pin,
  output logic [NUM_CH-1:0] output_pin_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [1:0][7:0] lsel;
    logic [1:0][1:0] lmask;
    logic [1:0] port;
    logic [7:0] noise;
    logic [7:0] bl_upd;
    logic [7:0] settle;
    logic [7:0] clk_ar;
    tbl_mode_t mode;
    logic [7:0] rdata;
    logic [2:0] div_cnt;
    logic tick;
    tbl_settle_t st;
    logic [7:0] settle_cnt;
    logic done;
  } tbl_top_st_t;

  tbl_top_st_t s_reg;
  tbl_top_st_t s_next;

  logic [1:0] ch_mask;
  logic [1:0] pin_en2;
  logic [1:0] sense2;
  logic [1:0] pin_lvl2;
  logic [NUM_CH-1:0] pin_lvl;
  logic [2:0] dmask;

  // channels above NUM_CH read as absent
  function automatic logic [1:0] present_mask(input int unsigned n);
    return (n > 1) ? 2'h3 : 2'h1;
  endfunction

  // a setting below the minimum still gives the documented shortest delay
  function automatic logic [7:0] settle_len(input logic [7:0] v);
    return (v < SETTLE_MIN) ? SETTLE_MIN : v;
  endfunction

  always_comb begin
    ch_mask = present_mask(NUM_CH);
    pin_en2 = 2'h0;
    sense2 = 2'h0;
    pin_lvl2 = 2'h0;
    for (int i = 0; i < NUM_CH; i++) begin
      pin_en2[i] = pin_enable[i];
      sense2[i] = sensor_active[i];
      pin_lvl2[i] = pin_lvl[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes, read mux, divider, settling timer

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    dmask = tbl_div_mask(s_reg.clk_ar[CLK_SEL_LSB +: 2]);

    if (reg_wr) begin
      case (reg_addr)
        OFF_LSEL0: begin
          if (pin_en2[0]) begin
            s_next.lsel[0] = reg_wdata & LSEL_WMASK;
          end
        end
        OFF_LSEL1: begin
          // second output only exists on the two-channel build
          if (ch_mask[1] && pin_en2[1]) begin
            s_next.lsel[1] = reg_wdata & LSEL_WMASK;
          end
        end
        OFF_LIN0: begin
          s_next.lmask[0] = reg_wdata[1:0] & ch_mask;
        end
        OFF_LIN1: begin
          if (ch_mask[1]) begin
            s_next.lmask[1] = reg_wdata[1:0] & ch_mask;
          end
        end
        OFF_OUT_PORT: begin
          s_next.port = reg_wdata[1:0] & ch_mask;
        end
        OFF_NOISE: begin
          s_next.noise = reg_wdata;
        end
        OFF_BL_UPD: begin
          s_next.bl_upd = reg_wdata;
        end
        OFF_SETTLE: begin
          if (s_reg.mode == TBL_MODE_SETUP) begin
            s_next.settle = reg_wdata;
          end
        end
        OFF_CLK_AR: begin
          if (s_reg.mode == TBL_MODE_SETUP) begin
            s_next.clk_ar = reg_wdata & CLK_AR_WMASK;
          end
        end
        OFF_COMMAND: begin
          if (reg_wdata == CMD_SETUP) begin
            s_next.mode = TBL_MODE_SETUP;
          end else if (reg_wdata == CMD_NORMAL) begin
            s_next.mode = TBL_MODE_NORMAL;
          end
        end
        default: begin
        end
      endcase
    end

    // read data is registered: valid the cycle after the address
    case (reg_addr)
      OFF_OUT_STATUS: s_next.rdata = {6'h00, pin_lvl2};
      OFF_OUT_PORT: s_next.rdata = {6'h00, s_reg.port};
      OFF_LSEL0: s_next.rdata = s_reg.lsel[0];
      OFF_LIN0: s_next.rdata = {6'h00, s_reg.lmask[0]};
      OFF_LSEL1: s_next.rdata = s_reg.lsel[1];
      OFF_LIN1: s_next.rdata = {6'h00, s_reg.lmask[1]};
      OFF_NOISE: s_next.rdata = s_reg.noise;
      OFF_BL_UPD: s_next.rdata = s_reg.bl_upd;
      OFF_SETTLE: s_next.rdata = s_reg.settle;
      OFF_CLK_AR: s_next.rdata = s_reg.clk_ar;
      default: s_next.rdata = 8'h00;
    endcase

    // free-running divider; the tick marks one sensing clock period
    s_next.div_cnt = s_reg.div_cnt + 3'h1;
    s_next.tick = (s_reg.div_cnt & dmask) == dmask;

    unique case (s_reg.st)
      TBL_ST_IDLE: begin
        if (conv_start) begin
          s_next.settle_cnt = settle_len(s_reg.settle);
          s_next.st = TBL_ST_SETTLE;
        end
      end
      TBL_ST_SETTLE: begin
        if (s_reg.tick) begin
          if (s_reg.settle_cnt == 8'h01) begin
            s_next.done = 1'b1;
            s_next.st = TBL_ST_IDLE;
          end else begin
            s_next.settle_cnt = s_reg.settle_cnt - 8'h01;
          end
        end
      end
      default: begin
        s_next.st = TBL_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.lsel <= {RST_LSEL, RST_LSEL};
      s_reg.lmask <= {RST_LIN1[1:0], RST_LIN0[1:0]};
      s_reg.port <= RST_OUT_PORT;
      s_reg.noise <= RST_NOISE;
      s_reg.bl_upd <= RST_BL_UPD;
      s_reg.settle <= RST_SETTLE;
      s_reg.clk_ar <= RST_CLK_AR;
      s_reg.mode <= TBL_MODE_NORMAL;
      s_reg.st <= TBL_ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;
  assign setup_mode = (s_reg.mode == TBL_MODE_SETUP);
  assign sense_tick = s_reg.tick;
  assign settle_busy = (s_reg.st == TBL_ST_SETTLE);
  assign settle_done = s_reg.done;

  ////////////////////////////////////////////////////////////////////////////
  // shared baseline settings, one copy for all channels

  tbl_cfg_if cfg ();

  assign cfg.noise_threshold_value = s_reg.noise;
  assign cfg.bucket_fill_level = s_reg.bl_upd;
  assign cfg.sensor_auto_reset = s_reg.clk_ar[AUTO_RST_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // per-channel baseline trackers and output logic

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    tbl_baseline #(
      .CNT_W(CNT_W)
    ) u_baseline (
      .clk_sys(clk_sys),
      .srst(srst),
      .cfg(cfg),
      .sample_valid(sample_valid[g]),
      .raw_count(raw_count[g]),
      .baseline(baseline[g])
    );

    tbl_out_logic u_out (
      .clk_sys(clk_sys),
      .srst(srst),
      .output_logic_select(s_reg.lsel[g]),
      .sensor_input_mask(s_reg.lmask[g]),
      .port_bit(s_reg.port[g]),
      .pin_enable(pin_enable[g]),
      .sensor_state(sense2),
      .pin(pin_lvl[g]),
      .pin_oe_n(output_pin_oe_n[g])
    );
  end

  assign output_pin = pin_lvl;

endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top import tbl_pkg::*; ;
  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] msk;
    logic [1:0] act;
    logic port;
    logic pin;
  } tbl_row_t;
  localparam tbl_row_t ROWS [10] = '{
    '{8'h00, 8'h01, 2'h1, 1'h0, 1'h0}, '{8'h00, 8'h01, 2'h1, 1'h1, 1'h1},
    '{8'h80, 8'h01, 2'h1, 1'h0, 1'h1}, '{8'h80, 8'h01, 2'h0, 1'h1, 1'h0},
    '{8'h80, 8'h03, 2'h2, 1'h0, 1'h1}, '{8'h81, 8'h03, 2'h1, 1'h0, 1'h0},
    '{8'h81, 8'h03, 2'h3, 1'h0, 1'h1}, '{8'h82, 8'h01, 2'h1, 1'h0, 1'h0},
    '{8'h83, 8'h03, 2'h1, 1'h0, 1'h1}, '{8'h81, 8'h00, 2'h3, 1'h0, 1'h0}};
  localparam logic [15:0] RST_TAB [11] = '{16'h1c00, 16'h1e01, 16'h2100, 16'h2302, 16'h4e28,
    16'h4f64, 16'h50a0, 16'h5100, 16'h0400, 16'h3000, 16'ha000};
  // settling value written, ticks expected; values below two count as two
  localparam logic [15:0] STL [4] = '{16'h0505, 16'h0002, 16'h0102, 16'hffff};
  logic clk_sys = 1'h0;
  logic srst = 1'h1;
  logic conv_start = 1'h0;
  logic [1:0] sensor_active = 2'h0;
  logic [1:0] sample_valid = 2'h0;
  logic [1:0] pin_enable = 2'h3;
  logic [1:0][15:0] raw_count = '0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, setup_mode, sense_tick, settle_busy, settle_done;
  logic [1:0] output_pin, oe_n;
  logic [1:0][15:0] baseline;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  always #12.5 clk_sys = ~clk_sys;
  tbl_top #(.NUM_CH(2), .CNT_W(16)) uut (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .setup_mode(setup_mode), .sensor_active(sensor_active),
    .sample_valid(sample_valid), .raw_count(raw_count), .baseline(baseline),
    .conv_start(conv_start), .sense_tick(sense_tick), .settle_busy(settle_busy),
    .settle_done(settle_done), .pin_enable(pin_enable), .output_pin(output_pin),
    .output_pin_oe_n(oe_n));
  tbl_host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr));
  ////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    check({8'h00, d}, {8'h00, exp});
  endtask
  // same raw count on both channels, so shared settings show on each
  task automatic smp(input logic [15:0] r);
    @(negedge clk_sys);
    sample_valid = 2'h3;
    raw_count = {r, r};
    @(negedge clk_sys);
    sample_valid = 2'h0;
    @(negedge clk_sys);
  endtask
  // a hung wait would otherwise never reach the verdict
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      n_errors++;
      $display("unexpected at %0t: timeout", $time);
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clk_sys);
    srst = 1'h0;
    foreach (ROWS[i]) begin
      host.wr(OFF_LSEL0, ROWS[i].sel);
      host.wr(OFF_LIN0, ROWS[i].msk);
      host.wr(OFF_OUT_PORT, {7'h00, ROWS[i].port});
      sensor_active = ROWS[i].act;
      repeat (3) @(negedge clk_sys);
      check({15'h0, output_pin[0]}, {15'h0, ROWS[i].pin});
    end
    $display("test logic done");
    srst = 1'h1;
    repeat (3) @(negedge clk_sys);
    srst = 1'h0;
    foreach (RST_TAB[i]) rd_chk(RST_TAB[i][15:8], RST_TAB[i][7:0]);
    $display("test reset done");
    pin_enable = 2'h2;
    host.wr(OFF_LSEL0, 8'h83);
    check({14'h0, oe_n}, 16'h0001);
    rd_chk(OFF_LSEL0, RST_LSEL);
    pin_enable = 2'h3;
    host.wr(OFF_LSEL1, 8'h83);
    rd_chk(OFF_LSEL1, 8'h83);
    pin_enable = 2'h1;
    host.wr(OFF_LSEL1, 8'h00);
    check({14'h0, oe_n}, 16'h0002);
    rd_chk(OFF_LSEL1, 8'h83);
    pin_enable = 2'h3;
    host.wr(OFF_SETTLE, 8'h05);
    rd_chk(OFF_SETTLE, RST_SETTLE);
    $display("test refuse done");
    host.mode(1'h1);
    check({15'h0, setup_mode}, 16'h1);
    for (int c = 0; c < 4; c++) begin
      host.wr(OFF_CLK_AR, 8'(c << 4));
      repeat (9) @(negedge clk_sys);
      n = 0;
      repeat (64) begin
        @(negedge clk_sys);
        if (sense_tick === 1'h1) n++;
      end
      check(16'(n), 16'(64 >> c));
    end
    $display("test clock done");
    foreach (STL[i]) begin
      host.wr(OFF_SETTLE, STL[i][15:8]);
      conv_start = 1'h1;
      @(negedge clk_sys);
      conv_start = 1'h0;
      n = 0;
      for (int k = 0; k < 2400; k++) begin
        if (sense_tick === 1'h1 && (settle_busy === 1'h1 || settle_done === 1'h1)) n++;
        if (settle_done === 1'h1) break;
        @(negedge clk_sys);
      end
      check(16'(n), {8'h00, STL[i][7:0]});
    end
    host.mode(1'h0);
    check({15'h0, setup_mode}, 16'h0);
    host.wr(OFF_CLK_AR, 8'h08);
    rd_chk(OFF_CLK_AR, 8'h30);
    $display("test settle done");
    // forty percent of a finger threshold of one hundred
    host.wr(OFF_NOISE, RST_NOISE);
    host.wr(OFF_BL_UPD, 8'h03);
    smp(16'h0064);
    smp(16'h0066);
    smp(16'h0066);
    check(baseline[0], 16'h0065);
    check(baseline[1], 16'h0065);
    smp(16'h008d);
    smp(16'h008d);
    check(baseline[0], 16'h0065);
    host.mode(1'h1);
    host.wr(OFF_CLK_AR, 8'h38);
    host.mode(1'h0);
    smp(16'h008d);
    check(baseline[1], 16'h0066);
    $display("test baseline done");
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- sim/tbl_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tbl_host_model import tbl_pkg::*; (
  // register bus
  input wire logic clk_sys,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
  end
  // requests change at the falling edge so the rising edge never races them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = (a == OFF_NOISE && d < 8'h03) ? 8'h03 : d;
    reg_wr = 1'h1;
    @(negedge clk_sys);
    reg_wr = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic mode(input logic setup);
    wr(OFF_COMMAND, setup ? CMD_SETUP : CMD_NORMAL);
  endtask
endmodule
`default_nettype wire

// ---- sim/tbl_top_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module tbl_top_chk import tbl_pkg::*; #(
  parameter int unsigned NUM_CH = 2,
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register access
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic setup_mode,
  // sensing core
  input wire logic [NUM_CH-1:0] sensor_active,
  input wire logic [NUM_CH-1:0] sample_valid,
  input wire logic [NUM_CH-1:0][CNT_W-1:0] raw_count,
  input wire logic [NUM_CH-1:0][CNT_W-1:0] baseline,
  input wire logic conv_start,
  input wire logic sense_tick,
  input wire logic settle_busy,
  input wire logic settle_done,
  // output pins
  input wire logic [NUM_CH-1:0] pin_enable,
  input wire logic [NUM_CH-1:0] output_pin
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////
  // shadows of channel 0 settings, rebuilt from writes seen at the ports
  logic [7:0] sel_reg, msk_reg, nt_reg;
  logic [1:0] div_reg, div_q, hit;
  logic ar_reg, primed_reg, exp_pin, big_up;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sel_reg <= RST_LSEL;
      msk_reg <= RST_LIN0;
      nt_reg <= RST_NOISE;
      div_reg <= 2'h0;
      div_q <= 2'h0;
      ar_reg <= 1'h0;
      primed_reg <= 1'h0;
    end else begin
      div_q <= div_reg;
      if (sample_valid[0]) primed_reg <= 1'h1;
      if (reg_wr && reg_addr == OFF_LSEL0 && pin_enable[0]) sel_reg <= reg_wdata & LSEL_WMASK;
      if (reg_wr && reg_addr == OFF_LIN0) msk_reg <= reg_wdata;
      if (reg_wr && reg_addr == OFF_NOISE) nt_reg <= reg_wdata;
      if (reg_wr && reg_addr == OFF_CLK_AR && setup_mode) begin
        div_reg <= reg_wdata[5:4];
        ar_reg <= reg_wdata[3];
      end
    end
  end
  assign hit = msk_reg[1:0] & 2'(sensor_active);
  assign exp_pin = (sel_reg[0] ? (hit == msk_reg[1:0] && hit != 2'h0) : hit != 2'h0) ^ sel_reg[1];
  assign big_up = primed_reg && !ar_reg && raw_count[0] > baseline[0]
    && raw_count[0] - baseline[0] >= CNT_W'(nt_reg);
  ////////////////////////////////////////////////////////////
  AST_SETUP_CMD: assert property (reg_wr && reg_addr == OFF_COMMAND && reg_wdata == CMD_SETUP
    |=> setup_mode) else $error("setup command ignored");
  AST_NORMAL_CMD: assert property (reg_wr && reg_addr == OFF_COMMAND && reg_wdata == CMD_NORMAL
    |=> !setup_mode) else $error("normal command ignored");
  AST_SETTLE_START: assert property (conv_start && !settle_busy |=> settle_busy)
    else $error("settling did not start");
  AST_SETTLE_END: assert property (settle_done |-> !settle_busy && $past(settle_busy))
    else $error("done pulse outside a settling run");
  AST_TICK_FULL: assert property (div_reg == 2'h0 && div_q == 2'h0 && sense_tick |=> sense_tick)
    else $error("undivided sense tick missing");
  AST_TICK_DIV8: assert property (div_reg == 2'h3 && div_q == 2'h3 && sense_tick
    |=> !sense_tick [*7] ##1 sense_tick) else $error("divide by eight spacing wrong");
  AST_LOGIC_PIN: assert property (sel_reg[7] |=> output_pin[0] == $past(exp_pin))
    else $error("logic driven pin wrong");
  AST_NO_UPDATE: assert property (sample_valid[0] && big_up
    |=> baseline[0] == $past(baseline[0])) else $error("baseline moved above noise");
  AST_STEP_ONE: assert property (sample_valid[0] && primed_reg && raw_count[0] >= baseline[0]
    |=> baseline[0] - $past(baseline[0]) <= CNT_W'(1)) else $error("baseline rose by more than one");
  cover property (settle_done);
  cover property (sel_reg[7] && output_pin[0]);
  cover property (sample_valid[0] && big_up);
endmodule
bind tbl_top tbl_top_chk #(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) u_chk (
  .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .setup_mode(setup_mode), .sensor_active(sensor_active), .sample_valid(sample_valid),
  .raw_count(raw_count), .baseline(baseline), .conv_start(conv_start), .sense_tick(sense_tick),
  .settle_busy(settle_busy), .settle_done(settle_done), .pin_enable(pin_enable),
  .output_pin(output_pin));
`default_nettype wire
